// *** hdl/cps_pkg.sv ***
// constants and carrier types for the process-data scheduler
// assumes a single 125 mhz clock and a synchronous active-high reset
package cps_pkg;
  // -------------------------------------------------------------
  // timing
  // -------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned TB_US = 1000; // timer tick period in microseconds
  localparam int unsigned TB_CYC = TB_US * CLK_MHZ;
  // -------------------------------------------------------------
  // register byte offsets
  // -------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TTYPE = 8'h04;
  localparam logic [7:0] OFS_EVT = 8'h08;
  localparam logic [7:0] OFS_INH = 8'h0c;
  localparam logic [7:0] OFS_INLEN = 8'h10;
  localparam logic [7:0] OFS_OUTLEN = 8'h14;
  localparam logic [7:0] OFS_STATE = 8'h18;
  localparam logic [7:0] OFS_ERR = 8'h1c;
  localparam logic [7:0] OFS_SLVCFG = 8'h20;
  localparam logic [7:0] OFS_ACTIVE = 8'h24;
  localparam logic [7:0] OFS_IDX = 8'h28;
  localparam logic [7:0] OFS_INDATA = 8'h2c;
  localparam logic [7:0] OFS_OUTDATA = 8'h30;
  // control register fields
  localparam int CTRL_RUN = 0;
  localparam int CTRL_STOP = 1;
  localparam int CTRL_DL_BEGIN = 2;
  localparam int CTRL_DL_END = 3;
  localparam int CTRL_MASTER = 4;
  localparam int CTRL_MAND = 5;
  // reset values
  localparam logic [7:0] RST_TTYPE = 8'hfe;
  localparam logic [15:0] RST_TIMER = 16'h0000;
  localparam logic [8:0] RST_LEN = 9'h000;
  // -------------------------------------------------------------
  // transmission types, areas, object dictionary, error codes
  // -------------------------------------------------------------
  localparam logic [7:0] TT_ACYC = 8'h00;
  localparam logic [7:0] TT_SYNC_MAX = 8'hf0;
  localparam logic [7:0] TT_ASYNC = 8'hfe;
  localparam logic [7:0] TT_ASYNC_PROF = 8'hff;
  localparam logic [8:0] MASTER_WORDS = 9'h1e0;
  localparam logic [8:0] SLAVE_WORDS = 9'h020;
  localparam logic [15:0] OD_OUT_AREA = 16'h2000;
  localparam logic [15:0] OD_IN_AREA = 16'h2001;
  localparam logic [7:0] OD_SUB_MAX = 8'h20;
  localparam logic [15:0] ERR_NONE = 16'h0000;
  localparam logic [15:0] ERR_MAND = 16'h0001;
  localparam logic [15:0] ERR_LOCK = 16'h0002;
  // module state codes
  typedef enum logic [7:0] {
    CPS_INIT = 8'b0000_0000,
    CPS_STOP = 8'b0000_0100,
    CPS_RUN = 8'b0000_0101,
    CPS_UNKNOWN = 8'b0000_1111,
    CPS_PREOP = 8'b0111_1111
  } cps_state_t;
  // received process-data word
  typedef struct packed {
    logic last;
    logic [15:0] data;
  } cps_word_t;
  // object dictionary request
  typedef struct packed {
    logic wr;
    logic [15:0] index;
    logic [7:0] sub;
    logic [15:0] wdata;
  } cps_od_req_t;
endpackage

// *** hdl/cps_top.sv ***
// process-data scheduler, state exchange and mapping areas, plus its receive fifo
// assumes an apb master on the same clock and network logic that drives sync,
// received words and slave status synchronously to clock
//
// Summary of operation
// - types 3 to 240 transmit on every n-th sync, like types 1 and 2; received objects apply at the next sync
// - type 1 sends after each sync; received objects apply at next sync
// - type 2 sends after every two syncs
// - type 254 received objects apply immediately without waiting for sync
// - type 254 with both timers zero sends only on content change
// - type 254 with nonzero timers sends periodically at the event interval
// - with both timers nonzero, further sends after each send wait for the inhibit interval
// - with nonzero timers a content change also triggers a send, inhibit honoured
// - type 255 behaves exactly as type 254
// - master mode areas configurable from 0 to 480 words
// - slave mode areas configurable from 0 to 32 words
// - slave objects 2000h read/write output area, 2001h read-only input area
// - two-word exchange: state word then error word
// - state codes: init 00, stop 04, run 05, preop 7f, unknown 0f
// - mandatory config: first start needs every configured slave online
// - optional config: missing slaves skipped, others exchange data
// - stop before download; run again only on explicit command
//
// The address map and register access over APB are this design's own decisions.

// ---------------------------------------------------------------
// fifo
// ---------------------------------------------------------------
module cps_fifo #(
  parameter int W = 17,
  parameter int D = 16
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(D);
  initial begin
    if (D < 2 || (1 << AW) != D) $error("cps_fifo depth must be a power of two");
  end
  logic [W-1:0] mem [D];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0] cnt;
  logic push;
  logic pop;
  logic [AW:0] next_cnt;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_valid = cnt != '0;
  assign out_data = mem[rp];
  assign next_cnt = cnt + (AW+1)'(push) - (AW+1)'(pop);
  // pointers and fill; ready is registered so it never depends on the writer
  always_ff @(posedge clock) begin
    if (rst) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
      in_ready <= 1'b0;
    end else if (ce) begin
      if (push) wp <= wp + 1'b1;
      if (pop) rp <= rp + 1'b1;
      cnt <= next_cnt;
      in_ready <= next_cnt < (AW+1)'(D);
    end
  end
  always_ff @(posedge clock) begin
    if (ce && push) mem[wp] <= in_data;
  end
endmodule // cps_fifo

// ---------------------------------------------------------------
// top
// ---------------------------------------------------------------
module cps_top #(
  parameter int NSLV = 32,
  parameter int FIFO_D = 16,
  parameter int unsigned TICK_CYC = cps_pkg::TB_CYC
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sync_pulse,
  input wire logic rx_valid,
  input wire cps_pkg::cps_word_t rx_word,
  output logic rx_ready,
  input wire logic [NSLV-1:0] slave_ok,
  input wire logic od_valid,
  input wire cps_pkg::cps_od_req_t od_req,
  output logic [15:0] od_rdata,
  output logic od_done,
  output logic od_abort,
  output logic tx_start
);
  initial begin
    if (NSLV < 1 || NSLV > 32) $error("cps_top slave count must be 1 to 32");
    if (TICK_CYC < 2) $error("cps_top tick must be at least two cycles");
  end
  localparam int MW = 480; // array depth equals the largest area
  cps_pkg::cps_state_t state;
  logic [15:0] err_word;
  logic master_mode, mandatory, first_start, dl_open;
  logic [7:0] ttype;
  logic [15:0] evt_set, inh_set, evt_cnt, inh_cnt;
  logic [8:0] in_len, out_len, idx, out_wp;
  logic [NSLV-1:0] slv_cfg, active;
  logic [15:0] in_area [MW];
  logic [15:0] out_area [MW];
  logic chg, armed, tick;
  logic [7:0] sync_cnt;
  logic [31:0] tb_cnt;
  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  logic acc, wr, rd_ok, cfg_hit, run_cmd, stop_cmd, dl_begin, dl_end;
  logic [8:0] len_max, wlen;
  logic missing, is_async, is_sync;
  assign acc = psel && penable && !pready;
  assign wr = acc && pwrite;
  assign cfg_hit = paddr == cps_pkg::OFS_TTYPE || paddr == cps_pkg::OFS_EVT || paddr == cps_pkg::OFS_INH
    || paddr == cps_pkg::OFS_INLEN || paddr == cps_pkg::OFS_OUTLEN || paddr == cps_pkg::OFS_SLVCFG;
  assign run_cmd = wr && paddr == cps_pkg::OFS_CTRL && pwdata[cps_pkg::CTRL_RUN];
  assign stop_cmd = wr && paddr == cps_pkg::OFS_CTRL && pwdata[cps_pkg::CTRL_STOP];
  assign dl_begin = wr && paddr == cps_pkg::OFS_CTRL && pwdata[cps_pkg::CTRL_DL_BEGIN];
  assign dl_end = wr && paddr == cps_pkg::OFS_CTRL && pwdata[cps_pkg::CTRL_DL_END];
  assign len_max = master_mode ? cps_pkg::MASTER_WORDS : cps_pkg::SLAVE_WORDS;
  assign wlen = (pwdata[31:9] != '0 || pwdata[8:0] > len_max) ? len_max : pwdata[8:0];
  assign missing = (slave_ok & slv_cfg) != slv_cfg;
  assign is_async = ttype == cps_pkg::TT_ASYNC || ttype == cps_pkg::TT_ASYNC_PROF;
  assign is_sync = ttype != cps_pkg::TT_ACYC && ttype <= cps_pkg::TT_SYNC_MAX;
  always_comb begin
    case (paddr)
      cps_pkg::OFS_CTRL, cps_pkg::OFS_TTYPE, cps_pkg::OFS_EVT, cps_pkg::OFS_INH, cps_pkg::OFS_INLEN,
      cps_pkg::OFS_OUTLEN, cps_pkg::OFS_STATE, cps_pkg::OFS_ERR, cps_pkg::OFS_SLVCFG, cps_pkg::OFS_ACTIVE,
      cps_pkg::OFS_IDX, cps_pkg::OFS_INDATA, cps_pkg::OFS_OUTDATA: rd_ok = 1'b1;
      default: rd_ok = 1'b0;
    endcase
  end
  // answer in the second access cycle; config writes while running are refused
  always_ff @(posedge clock) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else if (ce) begin
      pready <= acc;
      pslverr <= acc && (!rd_ok || (pwrite && cfg_hit && state == cps_pkg::CPS_RUN));
      prdata <= '0;
      if (acc && !pwrite) begin
        case (paddr)
          cps_pkg::OFS_CTRL: prdata <= {26'h0, mandatory, master_mode, 4'h0};
          cps_pkg::OFS_TTYPE: prdata <= {24'h0, ttype};
          cps_pkg::OFS_EVT: prdata <= {16'h0, evt_set};
          cps_pkg::OFS_INH: prdata <= {16'h0, inh_set};
          cps_pkg::OFS_INLEN: prdata <= {23'h0, in_len};
          cps_pkg::OFS_OUTLEN: prdata <= {23'h0, out_len};
          cps_pkg::OFS_STATE: prdata <= {24'h0, state};
          cps_pkg::OFS_ERR: prdata <= {16'h0, err_word};
          cps_pkg::OFS_SLVCFG: prdata <= 32'(slv_cfg);
          cps_pkg::OFS_ACTIVE: prdata <= 32'(active);
          cps_pkg::OFS_IDX: prdata <= {23'h0, idx};
          cps_pkg::OFS_INDATA: prdata <= {16'h0, in_area[idx]};
          cps_pkg::OFS_OUTDATA: prdata <= {16'h0, out_area[idx]};
          default: prdata <= '0;
        endcase
      end
    end
  end
  // configuration, writable only while not running
  always_ff @(posedge clock) begin
    if (rst) begin
      master_mode <= 1'b0;
      mandatory <= 1'b0;
      ttype <= cps_pkg::RST_TTYPE;
      evt_set <= cps_pkg::RST_TIMER;
      inh_set <= cps_pkg::RST_TIMER;
      in_len <= cps_pkg::RST_LEN;
      out_len <= cps_pkg::RST_LEN;
      slv_cfg <= '0;
      idx <= '0;
    end else if (ce && wr) begin
      if (state != cps_pkg::CPS_RUN) begin
        case (paddr)
          cps_pkg::OFS_CTRL: begin
            master_mode <= pwdata[cps_pkg::CTRL_MASTER];
            mandatory <= pwdata[cps_pkg::CTRL_MAND];
          end
          cps_pkg::OFS_TTYPE: ttype <= pwdata[7:0];
          cps_pkg::OFS_EVT: evt_set <= pwdata[15:0];
          cps_pkg::OFS_INH: inh_set <= pwdata[15:0];
          cps_pkg::OFS_INLEN: in_len <= wlen;
          cps_pkg::OFS_OUTLEN: out_len <= wlen;
          cps_pkg::OFS_SLVCFG: slv_cfg <= pwdata[NSLV-1:0];
          default: ;
        endcase
      end
      if (paddr == cps_pkg::OFS_IDX) idx <= (pwdata[8:0] < cps_pkg::MASTER_WORDS) ? pwdata[8:0] : '0;
      else if (paddr == cps_pkg::OFS_INDATA) idx <= (idx == len_max - 9'h1) ? '0 : idx + 9'h1;
    end
  end
  // ---------------------------------------------------------------
  // module state
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      state <= cps_pkg::CPS_INIT;
      err_word <= cps_pkg::ERR_NONE;
      first_start <= 1'b1;
      dl_open <= 1'b0;
      active <= '0;
    end else if (ce) begin
      if (wr && cfg_hit && state == cps_pkg::CPS_RUN) err_word <= cps_pkg::ERR_LOCK;
      if (dl_begin) dl_open <= 1'b1;
      else if (dl_end) begin
        dl_open <= 1'b0;
        first_start <= 1'b1; // a new configuration gets a fresh first-start check
      end
      case (state)
        cps_pkg::CPS_INIT: state <= cps_pkg::CPS_PREOP;
        cps_pkg::CPS_PREOP, cps_pkg::CPS_STOP: begin
          // leaving stop needs an explicit run, never a finished download
          if (run_cmd && !dl_open && !dl_begin) begin
            if (master_mode && mandatory && first_start && missing) begin
              err_word <= cps_pkg::ERR_MAND;
            end else begin
              state <= cps_pkg::CPS_RUN;
              first_start <= 1'b0;
              err_word <= cps_pkg::ERR_NONE;
              active <= master_mode ? (slv_cfg & slave_ok) : '0;
            end
          end
        end
        cps_pkg::CPS_RUN: if (stop_cmd || dl_begin) state <= cps_pkg::CPS_STOP;
        default: state <= cps_pkg::CPS_UNKNOWN;
      endcase
    end
  end
  // ---------------------------------------------------------------
  // input area and change detection
  // ---------------------------------------------------------------
  logic in_wr, tx_go;
  assign in_wr = wr && paddr == cps_pkg::OFS_INDATA;
  always_ff @(posedge clock) begin
    if (ce && in_wr) in_area[idx] <= pwdata[15:0];
  end
  // a change in the same cycle as a send stays pending: set wins
  always_ff @(posedge clock) begin
    if (rst) chg <= 1'b0;
    else if (ce) begin
      if (in_wr && idx < in_len && in_area[idx] != pwdata[15:0]) chg <= 1'b1;
      else if (tx_go) chg <= 1'b0;
    end
  end
  // ---------------------------------------------------------------
  // timers and scheduler
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      tb_cnt <= '0;
      tick <= 1'b0;
    end else if (ce) begin
      tick <= tb_cnt == TICK_CYC - 1;
      tb_cnt <= (tb_cnt == TICK_CYC - 1) ? '0 : tb_cnt + 32'h1;
    end
  end
  logic timed, sync_due;
  assign timed = evt_set != '0 && inh_set != '0;
  assign sync_due = sync_pulse && (sync_cnt == ttype - 8'h1);
  always_comb begin
    tx_go = 1'b0;
    if (state == cps_pkg::CPS_RUN) begin
      if (is_async) tx_go = inh_cnt == '0 && (chg || (timed && evt_cnt == '0));
      else if (is_sync) tx_go = sync_due;
      else tx_go = sync_pulse && chg;
    end
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      sync_cnt <= '0;
      evt_cnt <= '0;
      inh_cnt <= '0;
      tx_start <= 1'b0;
    end else if (ce) begin
      tx_start <= tx_go;
      if (state != cps_pkg::CPS_RUN || sync_due) sync_cnt <= '0;
      else if (sync_pulse) sync_cnt <= sync_cnt + 8'h1;
      if (tx_go) begin
        evt_cnt <= timed ? evt_set : '0;
        inh_cnt <= timed ? inh_set : '0;
      end else if (tick) begin
        if (evt_cnt != '0) evt_cnt <= evt_cnt - 16'h1;
        if (inh_cnt != '0) inh_cnt <= inh_cnt - 16'h1;
      end
    end
  end
  // ---------------------------------------------------------------
  // receive path: words wait in the fifo until the object may apply
  // ---------------------------------------------------------------
  logic f_valid, f_ready;
  cps_pkg::cps_word_t f_word;
  cps_fifo #(.W($bits(cps_pkg::cps_word_t)), .D(FIFO_D)) u_fifo (
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .in_valid(rx_valid),
    .in_data(rx_word),
    .in_ready(rx_ready),
    .out_valid(f_valid),
    .out_data(f_word),
    .out_ready(f_ready)
  );
  // synchronous types hold the object until a sync arms the drain
  assign f_ready = is_async || armed;
  logic od_wr;
  always_ff @(posedge clock) begin
    if (rst) begin
      armed <= 1'b0;
      out_wp <= '0;
    end else if (ce) begin
      if (sync_pulse && f_valid) armed <= 1'b1;
      else if (f_valid && f_ready && f_word.last) armed <= 1'b0;
      if (f_valid && f_ready) out_wp <= (f_word.last || out_wp >= out_len - 9'h1) ? '0 : out_wp + 9'h1;
    end
  end
  always_ff @(posedge clock) begin
    if (ce) begin
      if (f_valid && f_ready && out_wp < out_len) out_area[out_wp] <= f_word.data;
      else if (od_wr) out_area[9'(od_req.sub) - 9'h1] <= od_req.wdata;
    end
  end
  // ---------------------------------------------------------------
  // slave object dictionary access
  // ---------------------------------------------------------------
  logic od_hit;
  localparam logic [7:0] OD_SUB_LIM = cps_pkg::OD_SUB_MAX;
  assign od_hit = !master_mode && od_req.sub != 8'h00 && od_req.sub <= OD_SUB_LIM;
  assign od_wr = od_valid && od_hit && od_req.wr && od_req.index == cps_pkg::OD_OUT_AREA;
  always_ff @(posedge clock) begin
    if (rst) begin
      od_done <= 1'b0;
      od_abort <= 1'b0;
      od_rdata <= '0;
    end else if (ce) begin
      od_done <= od_valid;
      od_abort <= 1'b0;
      od_rdata <= '0;
      if (od_valid) begin
        if (od_hit && od_req.index == cps_pkg::OD_OUT_AREA) od_rdata <= out_area[9'(od_req.sub) - 9'h1];
        else if (od_hit && od_req.index == cps_pkg::OD_IN_AREA && !od_req.wr)
          od_rdata <= in_area[9'(od_req.sub) - 9'h1];
        else od_abort <= 1'b1;
      end
    end
  end
  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  chk_inh_reload: assert property (@(posedge clock) disable iff (rst)
    ce && tx_go && timed |=> inh_cnt == inh_set && tx_start)
    else $error("inhibit not reloaded on send");
  chk_inh_block: assert property (@(posedge clock) disable iff (rst)
    is_async && inh_cnt != '0 |-> !tx_go)
    else $error("send during inhibit");
  chk_tx_running: assert property (@(posedge clock) disable iff (rst)
    tx_start |-> $past(state) == cps_pkg::CPS_RUN)
    else $error("send while not running");
  chk_chg_only: assert property (@(posedge clock) disable iff (rst)
    ce && is_async && !timed && !chg |=> !tx_start)
    else $error("send without change");
  chk_mand_hold: assert property (@(posedge clock) disable iff (rst)
    ce && (state == cps_pkg::CPS_PREOP || state == cps_pkg::CPS_STOP) && run_cmd && !dl_open && !dl_begin
    && master_mode && mandatory && first_start && missing |=> $stable(state) && err_word == cps_pkg::ERR_MAND)
    else $error("mandatory check bypassed");
  chk_len_limit: assert property (@(posedge clock) disable iff (rst)
    ce && wr && paddr == cps_pkg::OFS_INLEN && state != cps_pkg::CPS_RUN |=> in_len <= $past(len_max))
    else $error("area length over limit");
  chk_sync_hold: assert property (@(posedge clock) disable iff (rst)
    !armed && !sync_pulse |=> !armed)
    else $error("drain armed without a sync");
  chk_od_ro: assert property (@(posedge clock) disable iff (rst)
    ce && od_valid && od_req.wr && od_req.index == cps_pkg::OD_IN_AREA |=> od_done && od_abort)
    else $error("input area write accepted");
  chk_stop_dl: assert property (@(posedge clock) disable iff (rst)
    ce && state == cps_pkg::CPS_RUN && dl_begin |=> state == cps_pkg::CPS_STOP [*2])
    else $error("download while running");
endmodule // cps_top

// *** tb/cps_net_model.sv ***
// bus-side partner: sync source, output-word sender, object-dictionary client
// assumes the scheduler on the same clock; its tasks are entered at a rising edge
module cps_net_model #(
  parameter int NSLV = 32
) (
  input wire logic clock,
  input wire logic tx_start,
  output logic sync_pulse,
  output logic rx_valid,
  output cps_pkg::cps_word_t rx_word,
  input wire logic rx_ready,
  output logic [NSLV-1:0] slave_ok,
  output logic od_valid,
  output cps_pkg::cps_od_req_t od_req,
  input wire logic [15:0] od_rdata,
  input wire logic od_done,
  input wire logic od_abort
);
  timeunit 1ns;
  timeprecision 1ps;
  int tx_n = 0;
  logic [15:0] od_data;
  logic od_ab;
  initial begin
    slave_ok = '1; // every station online unless a test takes one away
    sync_pulse = 1'b0;
    rx_valid = 1'b0;
    rx_word = '0;
    od_valid = 1'b0;
    od_req = '0;
  end
  // count transmissions of the input object
  always @(posedge clock) if (tx_start === 1'b1) tx_n++;
  // one sync message, a single-cycle pulse
  task automatic sync();
    @(posedge clock);
    sync_pulse <= 1'b1;
    @(posedge clock);
    sync_pulse <= 1'b0;
  endtask
  // one-word output object, held until accepted; no sync sent with it
  task automatic send(input logic [15:0] d);
    @(posedge clock);
    rx_valid <= 1'b1;
    rx_word <= {1'b1, d};
    do @(posedge clock); while (rx_ready !== 1'b1);
    rx_valid <= 1'b0;
    rx_word <= ~rx_word; // a released line must not show the stale word
  endtask
  // one request, answer taken at the edge where done is seen
  task automatic od(input logic w, input logic [15:0] ix, input logic [7:0] s, input logic [15:0] d);
    @(posedge clock);
    od_valid <= 1'b1;
    od_req <= {w, ix, s, d};
    @(posedge clock);
    od_valid <= 1'b0;
    while (od_done !== 1'b1) @(posedge clock);
    od_data = od_rdata;
    od_ab = od_abort;
  endtask
  // change which stations report online
  task automatic online(input logic [NSLV-1:0] m);
    @(posedge clock);
    slave_ok <= m;
  endtask
endmodule // cps_net_model

// *** tb/canopen_pdo_scheduler_status_test.sv ***
// self-checking bench: apb register access plus the bus-side partner model
// assumes the scheduler runs with a 4-cycle timer tick
module canopen_pdo_scheduler_status_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, slave_ok, rd;
  logic pready, pslverr, sync_pulse, rx_valid, rx_ready, od_valid, od_done, od_abort, tx_start, er;
  logic [15:0] od_rdata;
  cps_pkg::cps_word_t rx_word;
  cps_pkg::cps_od_req_t od_req;
  int miscompares = 0, compares = 0, cyc = 0, base = 0;
  time t0;
  always #4 clock = ~clock;
  cps_top #(.TICK_CYC(4)) dut (.clock(clock), .rst(rst), .ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sync_pulse(sync_pulse), .rx_valid(rx_valid), .rx_word(rx_word), .rx_ready(rx_ready),
    .slave_ok(slave_ok), .od_valid(od_valid), .od_req(od_req), .od_rdata(od_rdata), .od_done(od_done),
    .od_abort(od_abort), .tx_start(tx_start));
  cps_net_model net (.clock(clock), .tx_start(tx_start), .sync_pulse(sync_pulse), .rx_valid(rx_valid),
    .rx_word(rx_word), .rx_ready(rx_ready), .slave_ok(slave_ok), .od_valid(od_valid), .od_req(od_req),
    .od_rdata(od_rdata), .od_done(od_done), .od_abort(od_abort));
  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  // one apb transfer; no fixed latency assumed, only the bench limit ends the wait
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
    chk(32'(er), 32'h0);
  endtask
  // restart in a new transmission type
  task automatic retype(input logic [7:0] t);
    apb(1'b1, cps_pkg::OFS_CTRL, 32'h1 << cps_pkg::CTRL_STOP);
    apb(1'b1, cps_pkg::OFS_TTYPE, 32'(t));
    apb(1'b1, cps_pkg::OFS_CTRL, 32'h1 << cps_pkg::CTRL_RUN);
    base = net.tx_n;
  endtask
  // settle, then compare transmissions since the last mark
  task automatic txc(input int e);
    repeat (6) @(posedge clock);
    chk(32'(net.tx_n - base), 32'(e));
    base = net.tx_n;
  endtask
  // wait for the next transmission of the input object
  task automatic txw();
    do @(posedge clock); while (tx_start !== 1'b1);
  endtask
  // control write: one command bit plus the stored mode bits
  task automatic ctl(input int b, input logic m, input logic y);
    apb(1'b1, cps_pkg::OFS_CTRL,
      (32'h1 << b) | (32'(m) << cps_pkg::CTRL_MASTER) | (32'(y) << cps_pkg::CTRL_MAND));
  endtask
  task automatic stop_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // hang guard, well above the few hundred cycles the tests need
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      stop_test();
    end
  end
  // -------------------------------------------------------------
  // tests
  // -------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    rdc(cps_pkg::OFS_STATE, 32'h7f);
    rdc(cps_pkg::OFS_ERR, 32'h0);
    apb(1'b0, 8'hfc, 32'h0);
    chk(32'(er), 32'h1);
    apb(1'b1, cps_pkg::OFS_INLEN, 32'h21);
    rdc(cps_pkg::OFS_INLEN, 32'h20);
    apb(1'b1, cps_pkg::OFS_INLEN, 32'h4);
    apb(1'b1, cps_pkg::OFS_OUTLEN, 32'h4);
    apb(1'b1, cps_pkg::OFS_INDATA, 32'h0); // memory has no reset: give word 0 a known value
    $display("test reset and sizes finished");
    // sync types: one send per n-th sync
    for (int t = 1; t <= 3; t++) begin
      retype(8'(t));
      rdc(cps_pkg::OFS_STATE, 32'h5);
      repeat (6) net.sync();
      txc(6 / t);
    end
    apb(1'b1, cps_pkg::OFS_TTYPE, 32'hfe);
    chk(32'(er), 32'h1);
    rdc(cps_pkg::OFS_ERR, 32'h2);
    $display("test sync types finished");
    // async types, both timers zero: send on change only
    for (int t = 254; t <= 255; t++) begin
      retype(8'(t));
      apb(1'b1, cps_pkg::OFS_IDX, 32'h0);
      apb(1'b1, cps_pkg::OFS_INDATA, 32'(t));
      txc(1);
      apb(1'b1, cps_pkg::OFS_IDX, 32'h0);
      apb(1'b1, cps_pkg::OFS_INDATA, 32'(t));
      txc(0);
    end
    $display("test change sends finished");
    // received object applies at once, without a sync
    net.send(16'hbeef);
    net.od(1'b0, cps_pkg::OD_OUT_AREA, 8'h01, 16'h0);
    chk(32'(net.od_data), 32'hbeef);
    net.od(1'b0, cps_pkg::OD_IN_AREA, 8'h01, 16'h0);
    chk(32'(net.od_data), 32'hff);
    net.od(1'b1, cps_pkg::OD_IN_AREA, 8'h01, 16'h5);
    chk(32'(net.od_ab), 32'h1);
    net.od(1'b0, cps_pkg::OD_OUT_AREA, 8'h21, 16'h0);
    chk(32'(net.od_ab), 32'h1);
    $display("test object access finished");
    // timed mode, 4-cycle tick: event every 3 ticks, a change held off 2 ticks
    apb(1'b1, cps_pkg::OFS_CTRL, 32'h1 << cps_pkg::CTRL_STOP);
    apb(1'b1, cps_pkg::OFS_EVT, 32'h3);
    apb(1'b1, cps_pkg::OFS_INH, 32'h2);
    apb(1'b1, cps_pkg::OFS_IDX, 32'h0);
    apb(1'b1, cps_pkg::OFS_CTRL, 32'h1 << cps_pkg::CTRL_RUN);
    txw();
    txw();
    t0 = $time;
    txw();
    chk(32'(($time - t0) / 8), 32'hc);
    t0 = $time;
    apb(1'b1, cps_pkg::OFS_INDATA, 32'h1234);
    txw();
    chk(32'(($time - t0) / 8), 32'h8);
    $display("test timed sends finished");
    // mandatory first start with a station missing, optional start, stop on download
    ctl(cps_pkg::CTRL_STOP, 1'b0, 1'b0);
    ctl(cps_pkg::CTRL_DL_BEGIN, 1'b0, 1'b0);
    ctl(cps_pkg::CTRL_DL_END, 1'b1, 1'b1);
    apb(1'b1, cps_pkg::OFS_SLVCFG, 32'h3);
    net.online(32'h1);
    ctl(cps_pkg::CTRL_RUN, 1'b1, 1'b1);
    rdc(cps_pkg::OFS_STATE, 32'h4);
    rdc(cps_pkg::OFS_ERR, 32'h1);
    ctl(cps_pkg::CTRL_MASTER, 1'b1, 1'b0);
    ctl(cps_pkg::CTRL_RUN, 1'b1, 1'b0);
    rdc(cps_pkg::OFS_STATE, 32'h5);
    rdc(cps_pkg::OFS_ACTIVE, 32'h1);
    ctl(cps_pkg::CTRL_DL_BEGIN, 1'b1, 1'b0);
    ctl(cps_pkg::CTRL_DL_END, 1'b1, 1'b0);
    rdc(cps_pkg::OFS_STATE, 32'h4);
    $display("test start and download finished");
    stop_test();
  end
endmodule // canopen_pdo_scheduler_status_test
